// ---- core/irq_controller.sv ----
// Four-level prioritised interrupt controller with brownout handling.
// Assumes the core takes a request with a one-cycle ack and signals return
// with a one-cycle pulse; all inputs synchronous to sys_clk.

module irq_controller (
  input wire logic sys_clk,                        // CPU clock
  input wire logic resetn,                         // Core reset, active low
  input wire logic por_n,                          // Power-on reset only, active low
  input wire logic ext0_request_flag,              // External pin 0 request
  input wire logic tmr0_overflow_flag,             // Timer 0 overflow
  input wire logic tmr1_overflow_flag,             // Timer 1 overflow
  input wire logic uart_tx_done,                   // UART transmit done
  input wire logic uart_rx_done,                   // UART receive done
  input wire logic twowire_attention,              // Two-wire attention
  input wire logic keypad_flag,                    // Keypad event
  input wire logic watchdog_overflow_flag,         // Watchdog overflow
  input wire logic comparator_flag,                // Comparator event
  input wire logic timeout_flag,                   // Two-wire timeout timer
  input wire logic brownout_detect,                // Raw brownout detector
  input wire logic [7:0] irq_enable_reg_0,         // Enables, bit 7 global
  input wire logic [7:0] irq_enable_reg_1,         // Enables, second set
  input wire logic [7:0] priority_low_0,           // Level low bits, set 0
  input wire logic [7:0] priority_high_0,          // Level high bits, set 0
  input wire logic [7:0] priority_low_1,           // Level low bits, set 1
  input wire logic [7:0] priority_high_1,          // Level high bits, set 1
  input wire logic brownout_irq_select,            // 1: interrupt, 0: reset
  input wire logic brownout_disable,               // Detector disabled
  input wire logic watchdog_reset_select,          // Watchdog resets device
  input wire logic keypad_ready,                   // Keypad feature set up
  input wire logic comparator_ready,               // Comparator set up
  input wire logic power_down,                     // Core in power-down
  input wire logic brownout_flag_clear,            // Software clear pulse
  input wire logic irq_ack,                        // Core takes the offer
  input wire logic irq_return,                     // Return-from-interrupt pulse
  output logic irq_request,                        // Offer to the core
  output logic [irq_pkg::VEC_W-1:0] irq_vector,    // Offered vector
  output logic [irq_pkg::IDX_W-1:0] irq_source,    // Offered source index
  output logic [irq_pkg::LVL_W-1:0] irq_level,     // Offered level
  output logic [irq_pkg::NUM_LVL-1:0] in_service,  // Levels in service
  output logic brownout_flag,                      // Sticky brownout flag
  output logic brownout_pending,                   // Brownout request latched
  output logic brownout_reset,                     // Brownout reset out
  output logic wake_interrupt,                     // Wake by interrupt
  output logic wake_reset                          // Wake by reset
);

  // ----------------------------------------------------------------
  // Types and state
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b001,
    ST_OFFER  = 3'b010,
    ST_SETTLE = 3'b100
  } arb_state_e;

  arb_state_e state;
  arb_state_e next_state;
  logic det_prev;

  // ----------------------------------------------------------------
  // Source vector in poll order
  // ----------------------------------------------------------------
  // UART shares one slot for both directions.
  logic [irq_pkg::NUM_SRC-1:0] src_flag;
  assign src_flag[irq_pkg::SRC_EXT0] = ext0_request_flag;
  assign src_flag[irq_pkg::SRC_BROWN] = brownout_pending;
  assign src_flag[irq_pkg::SRC_WDOG] = watchdog_overflow_flag;
  assign src_flag[irq_pkg::SRC_TMR0] = tmr0_overflow_flag;
  assign src_flag[irq_pkg::SRC_TWI] = twowire_attention;
  assign src_flag[irq_pkg::SRC_KEY] = keypad_flag;
  assign src_flag[irq_pkg::SRC_CMP] = comparator_flag;
  assign src_flag[irq_pkg::SRC_TMR1] = tmr1_overflow_flag;
  assign src_flag[irq_pkg::SRC_UART] = uart_tx_done | uart_rx_done;
  assign src_flag[irq_pkg::SRC_TOUT] = timeout_flag;

  // Extra wake qualifiers; ones where no feature condition applies
  logic [irq_pkg::NUM_SRC-1:0] wake_extra;
  assign wake_extra[irq_pkg::SRC_EXT0] = 1'b1;
  assign wake_extra[irq_pkg::SRC_BROWN] = 1'b1;
  assign wake_extra[irq_pkg::SRC_WDOG] = ~watchdog_reset_select;
  assign wake_extra[irq_pkg::SRC_TMR0] = 1'b1;
  assign wake_extra[irq_pkg::SRC_TWI] = 1'b1;
  assign wake_extra[irq_pkg::SRC_KEY] = keypad_ready;
  assign wake_extra[irq_pkg::SRC_CMP] = comparator_ready;
  assign wake_extra[irq_pkg::SRC_TMR1] = 1'b1;
  assign wake_extra[irq_pkg::SRC_UART] = 1'b1;
  assign wake_extra[irq_pkg::SRC_TOUT] = 1'b1;

  // ----------------------------------------------------------------
  // Per-source enable and level decode
  // ----------------------------------------------------------------
  logic global_int_enable;
  logic [irq_pkg::NUM_SRC-1:0] src_enable;
  logic [irq_pkg::NUM_SRC-1:0] src_pend;
  logic [irq_pkg::NUM_SRC-1:0] src_wake;
  logic [2*irq_pkg::NUM_SRC-1:0] src_level;

  assign global_int_enable = irq_enable_reg_0[irq_pkg::GLOBAL_EN_BIT];

  // Enable and level share one bit position in their register set
  for (genvar g = 0; g < irq_pkg::NUM_SRC; g++) begin : g_src
    wire logic en0 = irq_enable_reg_0[irq_pkg::SRC_BIT[g]];
    wire logic en1 = irq_enable_reg_1[irq_pkg::SRC_BIT[g]];
    wire logic hi = irq_pkg::SRC_REG[g] ? priority_high_1[irq_pkg::SRC_BIT[g]]
                                        : priority_high_0[irq_pkg::SRC_BIT[g]];
    wire logic lo = irq_pkg::SRC_REG[g] ? priority_low_1[irq_pkg::SRC_BIT[g]]
                                        : priority_low_0[irq_pkg::SRC_BIT[g]];
    assign src_enable[g] = irq_pkg::SRC_REG[g] ? en1 : en0;
    assign src_level[2*g +: 2] = {hi, lo};
    assign src_pend[g] = src_flag[g] & src_enable[g] & global_int_enable;
    assign src_wake[g] = src_flag[g] & src_enable[g] & irq_pkg::SRC_WAKES[g] & wake_extra[g];
  end

  // ----------------------------------------------------------------
  // Arbitration
  // ----------------------------------------------------------------
  logic win_found;
  logic [irq_pkg::IDX_W-1:0] win_index;
  logic [irq_pkg::LVL_W-1:0] win_level;

  irq_arbiter #(
    .N(irq_pkg::NUM_SRC)
  ) u_arbiter (
    .pend(src_pend),
    .levels(src_level),
    .found(win_found),
    .index(win_index),
    .level(win_level)
  );

  // ----------------------------------------------------------------
  // Running priority and eligibility
  // ----------------------------------------------------------------
  // cur_prio is 0 when idle, else the top level in service plus one, so a
  // level-3 service (4) can never be beaten by any request.
  logic [2:0] cur_prio;
  logic [2:0] win_prio;
  logic eligible;

  assign cur_prio = in_service[3] ? 3'h4 :
                    in_service[2] ? 3'h3 :
                    in_service[1] ? 3'h2 :
                    in_service[0] ? 3'h1 : 3'h0;
  assign win_prio = {1'b0, win_level} + 3'h1;
  assign eligible = win_found && (win_prio > cur_prio);

  // ----------------------------------------------------------------
  // Level stack
  // ----------------------------------------------------------------
  // Return pops only the topmost level; a lower nested level stays marked.
  logic take;
  logic [irq_pkg::NUM_LVL-1:0] push_mask;
  logic [irq_pkg::NUM_LVL-1:0] pop_mask;
  logic [irq_pkg::NUM_LVL-1:0] next_in_service;

  assign take = (state == ST_OFFER) && irq_request && irq_ack;
  assign push_mask = take ? (4'h1 << irq_level) : 4'h0;
  assign pop_mask = !irq_return ? 4'h0 :
                    in_service[3] ? 4'h8 :
                    in_service[2] ? 4'h4 :
                    in_service[1] ? 4'h2 :
                    in_service[0] ? 4'h1 : 4'h0;
  assign next_in_service = (in_service & ~pop_mask) | push_mask;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      in_service <= irq_pkg::IN_SERVICE_RST;
    end else begin
      in_service <= next_in_service;
    end
  end

  // ----------------------------------------------------------------
  // Offer state machine
  // ----------------------------------------------------------------
  // Settle gives the stack one cycle to update before the next offer.
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (eligible) begin
          next_state = ST_OFFER;
        end
      end
      ST_OFFER: begin
        if (take) begin
          next_state = ST_SETTLE;
        end else if (!eligible) begin
          next_state = ST_IDLE;
        end
      end
      ST_SETTLE: begin
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  logic next_request;
  assign next_request = eligible && (next_state == ST_OFFER);

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state <= ST_IDLE;
      irq_request <= 1'b0;
      irq_source <= '0;
      irq_level <= '0;
      irq_vector <= irq_pkg::VECTOR_RST;
    end else begin
      state <= next_state;
      irq_request <= next_request;
      if (next_request) begin
        irq_source <= win_index;
        irq_level <= win_level;
        irq_vector <= irq_pkg::SRC_VECTOR[win_index];
      end
    end
  end

  // ----------------------------------------------------------------
  // Brownout: edge request, reset level, sticky flag
  // ----------------------------------------------------------------
  logic det_live;
  logic det_rise;
  logic bo_taken;

  assign det_live = brownout_detect & ~brownout_disable;
  assign det_rise = det_live & ~det_prev;
  assign bo_taken = take && (irq_source == irq_pkg::SRC_BROWN);

  // A new rising edge beats the ack that would clear the request
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      det_prev <= 1'b0;
      brownout_pending <= 1'b0;
      brownout_reset <= 1'b0;
    end else begin
      det_prev <= det_live;
      brownout_pending <= (det_rise & brownout_irq_select) | (brownout_pending & ~bo_taken);
      brownout_reset <= det_live & ~brownout_irq_select;
    end
  end

  // Flag lives on power-on reset only so the core reset leaves it alone.
  // Hazard: edge detect here restarts after a core reset, so a detector
  // still active then sets the flag again.
  always_ff @(posedge sys_clk or negedge por_n) begin
    if (!por_n) begin
      brownout_flag <= irq_pkg::BROWN_FLAG_POR;
    end else begin
      brownout_flag <= det_rise | (brownout_flag & ~brownout_flag_clear);
    end
  end

  // ----------------------------------------------------------------
  // Power-down wake qualification
  // ----------------------------------------------------------------
  // Wake ignores the global enable: the core must resume before it can
  // decide to run a handler at all.
  logic wake_by_reset;
  assign wake_by_reset = (watchdog_overflow_flag & watchdog_reset_select) |
                         (det_live & ~brownout_irq_select);

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      wake_interrupt <= 1'b0;
      wake_reset <= 1'b0;
    end else begin
      wake_interrupt <= power_down & (|src_wake);
      wake_reset <= power_down & wake_by_reset;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_global_block: assert property (@(posedge sys_clk) disable iff (!resetn)
    !global_int_enable |=> !irq_request) else $error("request with global enable clear");

  a_top_level_lock: assert property (@(posedge sys_clk) disable iff (!resetn)
    in_service[3] |=> !irq_request) else $error("request during top-level service");

  a_preempt_higher: assert property (@(posedge sys_clk) disable iff (!resetn)
    irq_request |-> (({1'b0, irq_level} + 3'h1) > $past(cur_prio))) else $error("offer not above running level");

  a_vector_match: assert property (@(posedge sys_clk) disable iff (!resetn)
    irq_request |-> (irq_vector == irq_pkg::SRC_VECTOR[irq_source])) else $error("vector does not match source");

  a_bo_reset_hold: assert property (@(posedge sys_clk) disable iff (!resetn)
    (brownout_detect && !brownout_disable && !brownout_irq_select) |=> brownout_reset)
    else $error("brownout reset dropped while detector active");

  a_bo_once: assert property (@(posedge sys_clk) disable iff (!resetn)
    $rose(brownout_pending) |-> ($past(det_live) && !$past(det_live, 2))) else $error("brownout request not on edge");

  a_flag_sticky: assert property (@(posedge sys_clk) disable iff (!por_n)
    (brownout_flag && !brownout_flag_clear) |=> brownout_flag) else $error("brownout flag lost");

  a_return_pops: assert property (@(posedge sys_clk) disable iff (!resetn)
    (irq_return && !take && (in_service != 4'h0)) |=>
      ($countones(in_service) == $countones($past(in_service)) - 1)) else $error("return did not pop a level");

  a_wake_gate: assert property (@(posedge sys_clk) disable iff (!resetn)
    wake_interrupt |-> ($past(power_down) && $past(|(src_flag & irq_pkg::SRC_WAKES)))) else $error("wake outside power-down");

  a_wake_needs_pd: assert property (@(posedge sys_clk) disable iff (!resetn)
    !power_down |=> (!wake_interrupt && !wake_reset)) else $error("wake while running");

  a_ext0_wake: assert property (@(posedge sys_clk) disable iff (!resetn)
    (power_down && ext0_request_flag && src_enable[irq_pkg::SRC_EXT0]) |=> wake_interrupt)
    else $error("enabled ext0 did not wake");

  a_wd_reset_wake: assert property (@(posedge sys_clk) disable iff (!resetn)
    (power_down && watchdog_overflow_flag && watchdog_reset_select) |=> wake_reset) else $error("no watchdog reset wake");

  a_settle_gap: assert property (@(posedge sys_clk) disable iff (!resetn)
    take |=> (!irq_request ##1 !irq_request)) else $error("offer during settle");

  a_push_level: assert property (@(posedge sys_clk) disable iff (!resetn)
    take |=> in_service[$past(irq_level)]) else $error("taken level not in service");

  a_source_range: assert property (@(posedge sys_clk) disable iff (!resetn)
    irq_request |-> (irq_source <= irq_pkg::SRC_TOUT)) else $error("offered source out of range");

  a_mask_source: assert property (@(posedge sys_clk) disable iff (!resetn)
    irq_request |-> (|($past(src_pend) & (10'h001 << irq_source)))) else $error("offer not pending");

  a_int_mode_quiet: assert property (@(posedge sys_clk) disable iff (!resetn)
    brownout_irq_select |=> !brownout_reset) else $error("brownout reset in interrupt mode");

  a_bo_disabled: assert property (@(posedge sys_clk) disable iff (!resetn)
    (brownout_disable && !brownout_pending) |=> (!brownout_pending && !brownout_reset))
    else $error("brownout acted while disabled");

  a_pend_cleared: assert property (@(posedge sys_clk) disable iff (!resetn)
    (bo_taken && !det_rise) |=> !brownout_pending) else $error("brownout request kept after take");

  a_flag_on_edge: assert property (@(posedge sys_clk) disable iff (!por_n)
    det_rise |=> brownout_flag) else $error("detection did not set brownout flag");

  // Per-source scan: nothing pending a cycle earlier should have beaten the offer
  for (genvar c = 0; c < irq_pkg::NUM_SRC; c++) begin : g_chk
    a_level_wins: assert property (@(posedge sys_clk) disable iff (!resetn)
      irq_request |-> !($past(src_pend[c]) && ($past(src_level[2*c +: 2]) > irq_level)))
      else $error("higher level left waiting");

    a_rank_wins: assert property (@(posedge sys_clk) disable iff (!resetn)
      irq_request |-> !($past(src_pend[c]) && ($past(src_level[2*c +: 2]) == irq_level) && (c < irq_source)))
      else $error("later rank beat earlier rank");
  end

endmodule : irq_controller

// ---- inc/irq_pkg.sv ----
// Constants for the four-level prioritised interrupt controller.
// Assumes one CPU clock, synchronous inputs, and sources ordered by tie-break rank.

package irq_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int NUM_SRC = 10;
  localparam int LVL_W = 2;
  localparam int IDX_W = 4;
  localparam int VEC_W = 16;
  localparam int NUM_LVL = 4;

  // ----------------------------------------------------------------
  // Source indices, ordered by tie-break rank (0 polls first)
  // ----------------------------------------------------------------
  localparam logic [3:0] SRC_EXT0 = 4'h0;
  localparam logic [3:0] SRC_BROWN = 4'h1;
  localparam logic [3:0] SRC_WDOG = 4'h2;
  localparam logic [3:0] SRC_TMR0 = 4'h3;
  localparam logic [3:0] SRC_TWI = 4'h4;
  localparam logic [3:0] SRC_KEY = 4'h5;
  localparam logic [3:0] SRC_CMP = 4'h6;
  localparam logic [3:0] SRC_TMR1 = 4'h7;
  localparam logic [3:0] SRC_UART = 4'h8;
  localparam logic [3:0] SRC_TOUT = 4'h9;

  // ----------------------------------------------------------------
  // Enable/priority field layout per source: register select and bit
  // ----------------------------------------------------------------
  localparam logic [2:0] GLOBAL_EN_BIT = 3'h7;
  localparam logic SRC_REG [0:NUM_SRC-1] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
  localparam logic [2:0] SRC_BIT [0:NUM_SRC-1] = '{3'h0, 3'h5, 3'h6, 3'h1, 3'h0, 3'h1, 3'h5, 3'h3, 3'h4, 3'h7};

  // Fixed vectors
  localparam logic [15:0] SRC_VECTOR [0:NUM_SRC-1] = '{16'h0003, 16'h002B, 16'h0053, 16'h000B, 16'h0033,
                                                       16'h003B, 16'h0063, 16'h001B, 16'h0023, 16'h0073};

  // Sources able to leave power-down
  localparam logic [NUM_SRC-1:0] SRC_WAKES = 10'h067;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [3:0] IN_SERVICE_RST = 4'h0;
  localparam logic [15:0] VECTOR_RST = 16'h0000;
  localparam logic BROWN_FLAG_POR = 1'b1;

endpackage : irq_pkg

// ---- core/irq_arbiter.sv ----
// Combinational arbiter: picks the highest level, then the lowest rank index.
// Assumes pending bits are already gated by enables.

module irq_arbiter #(
  parameter int N = irq_pkg::NUM_SRC
) (
  input wire logic [N-1:0] pend,           // Gated pending requests
  input wire logic [2*N-1:0] levels,       // Two-bit level per source
  output logic found,                      // Some request pending
  output logic [irq_pkg::IDX_W-1:0] index, // Winning source
  output logic [irq_pkg::LVL_W-1:0] level  // Level of the winner
);

  // ----------------------------------------------------------------
  // Selection
  // ----------------------------------------------------------------
  // Level scan ascending, index scan descending, so the last hit is the
  // highest level and the first in poll order within it.
  always_comb begin
    found = 1'b0;
    index = '0;
    level = '0;
    for (int l = 0; l < irq_pkg::NUM_LVL; l++) begin
      for (int i = N - 1; i >= 0; i--) begin
        if (pend[i] && (levels[2*i +: 2] == l[1:0])) begin
          found = 1'b1;
          index = i[irq_pkg::IDX_W-1:0];
          level = l[irq_pkg::LVL_W-1:0];
        end
      end
    end
  end

endmodule : irq_arbiter

// ---- bench/core_model.sv ----
// Behavioural core for the interrupt controller: takes offers after a set delay
// and records what it took. Assumes stimulus changes on the falling clock edge.

module core_model (
  input wire logic sys_clk,            // CPU clock
  input wire logic resetn,             // Core reset, active low
  input wire logic irq_request,        // Offer from controller
  input wire logic [15:0] irq_vector,  // Offered vector
  input wire logic [3:0] irq_source,   // Offered source
  input wire logic [1:0] irq_level,    // Offered level
  input wire logic [1:0] ack_wait,     // Cycles to stall before taking
  output logic irq_ack,                // One-cycle take pulse
  output logic took,                   // A take landed last edge
  output logic [21:0] cap              // Source, level, vector taken
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] cnt;

  initial begin
    irq_ack = 1'b0;
    cnt = 2'h0;
    took = 1'b0;
    cap = 22'h0;
  end

  // Ack is raised off the sampling edge and held until the next one takes it
  always @(negedge sys_clk) begin
    if (!resetn || irq_request !== 1'b1 || irq_ack) begin
      irq_ack <= 1'b0;
      cnt <= 2'h0;
    end else if (cnt == ack_wait) begin
      irq_ack <= 1'b1;
    end else begin
      cnt <= cnt + 2'h1;
    end
  end

  // Capture at the edge where the offer is really taken
  always @(posedge sys_clk) begin
    took <= irq_ack & irq_request;
    if (irq_ack & irq_request) begin
      cap <= {irq_source, irq_level, irq_vector};
    end
  end
endmodule : core_model

// ---- bench/tb_top.sv ----
// Self-checking bench for irq_controller with a behavioural core beside it.
// Assumes sources are given in rank order; brownout detector stands at rank 1.

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // Signals and tables
  // ----------------------------------------------------------------
  logic clk = 1'b0, rstn = 1'b0, por = 1'b0, rx = 1'b0, ret = 1'b0, bclr = 1'b0;
  logic bsel = 1'b1, bdis = 1'b0, wsel = 1'b0, kr = 1'b1, cr = 1'b1, pd = 1'b0;
  logic [9:0] fl = 10'h0;
  logic [15:0] en = 16'h0, ph = 16'h0, pl = 16'h0;
  logic [1:0] aw = 2'h0;
  logic req, bflag, bpend, brst, wint, wrst, ack, took;
  logic [15:0] vec;
  logic [3:0] src, isv;
  logic [1:0] lvl;
  logic [21:0] cap;
  int fail_count = 0, n_checks = 0, i;
  int pos[10] = '{0, 5, 6, 1, 8, 9, 13, 3, 4, 15};
  logic [15:0] vt[10] = '{16'h0003, 16'h002B, 16'h0053, 16'h000B, 16'h0033,
                          16'h003B, 16'h0063, 16'h001B, 16'h0023, 16'h0073};
  logic [9:0] wakes = 10'h067;

  initial begin
    forever #4 clk = ~clk;
  end

  irq_controller dut (.sys_clk(clk), .resetn(rstn), .por_n(por), .ext0_request_flag(fl[0]),
    .tmr0_overflow_flag(fl[3]), .tmr1_overflow_flag(fl[7]), .uart_tx_done(fl[8]), .uart_rx_done(rx),
    .twowire_attention(fl[4]), .keypad_flag(fl[5]), .watchdog_overflow_flag(fl[2]),
    .comparator_flag(fl[6]), .timeout_flag(fl[9]), .brownout_detect(fl[1]),
    .irq_enable_reg_0(en[7:0]), .irq_enable_reg_1(en[15:8]), .priority_low_0(pl[7:0]),
    .priority_high_0(ph[7:0]), .priority_low_1(pl[15:8]), .priority_high_1(ph[15:8]),
    .brownout_irq_select(bsel), .brownout_disable(bdis), .watchdog_reset_select(wsel),
    .keypad_ready(kr), .comparator_ready(cr), .power_down(pd), .brownout_flag_clear(bclr),
    .irq_ack(ack), .irq_return(ret), .irq_request(req), .irq_vector(vec), .irq_source(src),
    .irq_level(lvl), .in_service(isv), .brownout_flag(bflag), .brownout_pending(bpend),
    .brownout_reset(brst), .wake_interrupt(wint), .wake_reset(wrst));

  core_model core (.sys_clk(clk), .resetn(rstn), .irq_request(req), .irq_vector(vec), .irq_source(src),
    .irq_level(lvl), .ack_wait(aw), .irq_ack(ack), .took(took), .cap(cap));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [21:0] seen, input logic [21:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : chk

  // Source enable and level sit at the same bit position
  task automatic setsrc(input int s, input logic on, input logic [1:0] l);
    en[pos[s]] = on;
    ph[pos[s]] = l[1];
    pl[pos[s]] = l[0];
  endtask : setsrc

  // Bounded wait: a lost offer must not hang the run
  task automatic take(input int s, input logic [1:0] l);
    int k;
    k = 0;
    while (took !== 1'b1 && k < 20) begin
      @(negedge clk);
      k++;
    end
    if (k == 20) begin
      fail_count++;
      wrap_up();
    end
    chk(cap, {4'(s), l, vt[s]});
    @(negedge clk);
  endtask : take

  task automatic quiet(input int n);
    repeat (n) begin
      @(negedge clk);
      chk(req, 22'h0);
    end
  endtask : quiet

  task automatic ret_pulse();
    ret = 1'b1;
    @(negedge clk);
    ret = 1'b0;
    repeat (2) @(negedge clk);
  endtask : ret_pulse

  task automatic poke(input logic [9:0] f);
    fl = f;
    repeat (2) @(negedge clk);
  endtask : poke

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (6) @(negedge clk);
    rstn = 1'b1;
    por = 1'b1;
    @(negedge clk);
    chk({req, isv, vec}, 22'h0);
    chk(bflag, 22'h1);
    // All ten at one level, served strictly by rank with fixed vectors
    for (i = 0; i < 10; i++) setsrc(i, 1'b1, 2'h0);
    en[7] = 1'b1;
    aw = 2'h2;
    fl = 10'h3FF;
    for (i = 0; i < 10; i++) begin
      take(i, 2'h0);
      fl[i] = 1'b0;
      ret_pulse();
    end
    aw = 2'h0;
    rx = 1'b1;
    take(8, 2'h0);
    rx = 1'b0;
    ret_pulse();
    // Levels: higher wins, top level is never preempted
    setsrc(9, 1'b1, 2'h3);
    fl = 10'h201;
    take(9, 2'h3);
    quiet(6);
    chk(isv, 22'h8);
    fl[9] = 1'b0;
    ret_pulse();
    take(0, 2'h0);
    fl[0] = 1'b0;
    ret_pulse();
    setsrc(0, 1'b1, 2'h1);
    setsrc(3, 1'b1, 2'h1);
    setsrc(2, 1'b1, 2'h2);
    fl[0] = 1'b1;
    take(0, 2'h1);
    fl[3] = 1'b1;
    quiet(4);
    fl[2] = 1'b1;
    take(2, 2'h2);
    chk(isv, 22'h6);
    fl[0] = 1'b0;
    fl[2] = 1'b0;
    ret_pulse();
    chk(isv, 22'h2);
    ret_pulse();
    take(3, 2'h1);
    // Global off before the pop, so the still-flagged timer 0 is held back
    en[7] = 1'b0;
    ret_pulse();
    quiet(4);
    en[7] = 1'b1;
    setsrc(3, 1'b0, 2'h1);
    quiet(4);
    fl[3] = 1'b0;
    // Brownout as interrupt: needs its enable, raised once per detection
    setsrc(1, 1'b0, 2'h0);
    fl[1] = 1'b1;
    quiet(4);
    setsrc(1, 1'b1, 2'h0);
    take(1, 2'h0);
    // Pop first: with the level free, only a fresh edge could re-offer
    ret_pulse();
    quiet(4);
    chk({brst, bpend, isv}, 22'h0);
    fl[1] = 1'b0;
    bclr = 1'b1;
    @(negedge clk);
    bclr = 1'b0;
    @(negedge clk);
    chk(bflag, 22'h0);
    // Brownout as reset: held while the detector stays active
    bsel = 1'b0;
    fl[1] = 1'b1;
    repeat (5) begin
      @(negedge clk);
      chk(brst, 22'h1);
    end
    chk(bflag, 22'h1);
    fl[1] = 1'b0;
    bclr = 1'b1;
    bdis = 1'b1;
    @(negedge clk);
    bclr = 1'b0;
    fl[1] = 1'b1;
    repeat (3) @(negedge clk);
    chk({brst, bflag}, 22'h0);
    // Power-down wake qualification, global enable off throughout
    bdis = 1'b0;
    fl = 10'h0;
    pd = 1'b1;
    en = 16'hA37A;
    poke(10'h001);
    chk(wint, 22'h0);
    en[0] = 1'b1;
    kr = 1'b0;
    poke(10'h020);
    chk(wint, 22'h0);
    kr = 1'b1;
    wsel = 1'b1;
    poke(10'h004);
    chk({wrst, wint}, 22'h2);
    poke(10'h002);
    chk(wrst, 22'h1);
    wsel = 1'b0;
    bsel = 1'b1;
    for (i = 9; i >= 0; i--) begin
      poke(10'h0);
      poke(10'h1 << i);
      chk(wint, {21'h0, wakes[i]});
    end
    // A core reset leaves the set sticky flag alone but drops the request
    poke(10'h0);
    rstn = 1'b0;
    repeat (2) @(negedge clk);
    rstn = 1'b1;
    @(negedge clk);
    chk({bflag, bpend}, 22'h2);
    wrap_up();
  end
endmodule : tb_top
